/* sxd_pkg.sv */
// Constants for the swap, exclusive-OR and direction-load execute core
// Function
// - Nibble swap exchanges bits 3:0 and 7:4, flags untouched.
// - Nibble swap destination bit clear writes W, set writes file.
// - Direction load copies W to direction register 5..7, flags untouched.
// - Xor literal combines W with low byte into W, zero only.
// - Xor file combines W with seven-bit addressed file, zero only.
// - Xor file destination bit set writes file, clear writes W.
// - Every fetched instruction word is fourteen bits wide.
// - Accepted interrupt jumps to program address 0004h.
// - Any reset starts fetching at program address 0000h.
// - Hardware return stack holds eight entries.
// - Separate upper latch supplies high program address bits for paging.
// - Indirect pointer is a full eight-bit read/write register.
// - Register file of 128 bytes addressed by seven-bit field.
// - Enabled interrupt wakes the core from sleep.
package sxd_pkg;
  localparam int          INSTR_W      = 14;
  localparam int          PC_W         = 13;
  localparam int          DATA_W       = 8;
  localparam int          FADDR_W      = 7;
  localparam int          FILE_DEPTH   = 128;
  localparam int          STACK_DEPTH  = 8;
  localparam int          STACK_PTR_W  = 3;
  localparam int          LATCH_W      = 5;
  localparam logic [12:0] RESET_VECTOR = 13'h0000;
  localparam logic [12:0] IRQ_VECTOR   = 13'h0004;
  // Opcode fields
  localparam logic [5:0]  OPC_XOR_FILE = 6'h06;
  localparam logic [5:0]  OPC_SWAP     = 6'h0E;
  localparam logic [5:0]  OPC_XOR_LIT  = 6'h3A;
  localparam logic [10:0] OPC_DIR_LOAD = 11'h00C;
  localparam logic [2:0]  OPC_CALL     = 3'h4;
  localparam logic [2:0]  OPC_GOTO     = 3'h5;
  localparam logic [13:0] OPC_SLEEP    = 14'h0063;
  localparam logic [13:0] OPC_RETURN   = 14'h0008;
  localparam logic [13:0] OPC_RETFIE   = 14'h0009;
  localparam int          DEST_BIT     = 7;
  localparam logic [2:0]  DIR_SEL_LO   = 3'h5;
  // Special file addresses
  localparam logic [6:0]  ADDR_INDIRECT = 7'h00;
  localparam logic [6:0]  ADDR_POINTER  = 7'h04;
  localparam logic [6:0]  ADDR_LATCH    = 7'h0A;
  localparam logic [7:0]  DIR_RESET     = 8'hFF;
  typedef enum logic [2:0] {
    SXD_RUN   = 3'b001,
    SXD_FLUSH = 3'b010,
    SXD_SLEEP = 3'b100
  } sxd_state_e;
endpackage

/* sxd_stack.sv */
// Eight-entry return address stack
`timescale 1ns/100ps
module sxd_stack (
  // Clock and reset
  input  wire logic              mclk_i,
  input  wire logic              rst_b_i,
  // Push and pop
  input  wire logic              push_i,
  input  wire logic              pop_i,
  input  wire logic [12:0]       push_addr_i,
  output logic      [12:0]       top_o
);
  logic [12:0] mem_r [sxd_pkg::STACK_DEPTH];
  logic [2:0]  ptr_r;
  logic [2:0]  ptr_nxt;

  // Circular: a ninth push silently overwrites the oldest entry
  always_comb begin
    ptr_nxt = ptr_r;
    if (push_i) begin
      ptr_nxt = ptr_r + 3'h1;
    end else if (pop_i) begin
      ptr_nxt = ptr_r - 3'h1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      ptr_r <= 3'h0;
    end else begin
      ptr_r <= ptr_nxt;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (push_i) begin
      mem_r[ptr_r] <= push_addr_i;
    end
  end

  assign top_o = mem_r[ptr_r - 3'h1];
endmodule // sxd_stack

/* sxd_core.sv */
// Decode and execute core for swap, exclusive-OR and direction load
`timescale 1ns/100ps
module sxd_core (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  // Fetch path
  input  wire logic [13:0] instr_i,
  input  wire logic        instr_valid_i,
  output logic      [12:0] prog_addr_o,
  // Interrupt
  input  wire logic        irq_i,
  input  wire logic        irq_en_i,
  // Architectural state
  output logic      [7:0]  w_o,
  output logic             zero_o,
  output logic      [7:0]  ind_ptr_o,
  output logic      [4:0]  pc_latch_o,
  output logic             sleeping_o,
  // Direction registers
  output logic      [7:0]  dir_port5_o,
  output logic      [7:0]  dir_port6_o,
  output logic      [7:0]  dir_port7_o
);
  sxd_pkg::sxd_state_e st_r, st_nxt;
  logic [12:0] pc_r, pc_nxt;
  logic [7:0]  w_r, w_nxt;
  logic        zero_r, zero_nxt;
  logic [7:0]  ind_r, ind_nxt;
  logic [4:0]  lat_r, lat_nxt;
  logic        in_isr_r, in_isr_nxt;
  logic [7:0]  dir_r [3];
  logic [7:0]  dir_nxt [3];
  logic [7:0]  ram_r [sxd_pkg::FILE_DEPTH];
  logic        ram_we;
  logic [6:0]  ram_wa;
  logic [7:0]  ram_wd;
  logic        irq_s1_r, irq_s2_r;
  logic        push, pop;
  logic [12:0] stack_top;
  logic [12:0] push_addr;
  logic [6:0]  fa;
  logic [7:0]  fval;
  logic [7:0]  result;
  logic        to_file;
  logic        irq_take;

  // Seven-bit file field; address zero goes through the pointer
  function automatic logic [6:0] eff_addr(input logic [13:0] ins, input logic [7:0] ptr);
    eff_addr = (ins[6:0] == sxd_pkg::ADDR_INDIRECT) ? ptr[6:0] : ins[6:0];
  endfunction

  function automatic logic is_op6(input logic [13:0] ins, input logic [5:0] opc);
    is_op6 = (ins[13:8] == opc);
  endfunction

  // Pin level, two stages before use
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      irq_s1_r <= 1'b0;
      irq_s2_r <= 1'b0;
    end else begin
      irq_s1_r <= irq_i;
      irq_s2_r <= irq_s1_r;
    end
  end

  sxd_stack u_stack (
    .mclk_i      (mclk_i),
    .rst_b_i     (rst_b_i),
    .push_i      (push),
    .pop_i       (pop),
    .push_addr_i (push_addr),
    .top_o       (stack_top)
  );

  // File read mux; pointer and latch live outside the array
  always_comb begin
    fa = eff_addr(instr_i, ind_r);
    if (fa == sxd_pkg::ADDR_POINTER) begin
      fval = ind_r;
    end else if (fa == sxd_pkg::ADDR_LATCH) begin
      fval = {3'h0, lat_r};
    end else begin
      fval = ram_r[fa];
    end
  end

  assign irq_take = irq_s2_r && irq_en_i && !in_isr_r;

  always_comb begin
    st_nxt     = st_r;
    pc_nxt     = pc_r;
    w_nxt      = w_r;
    zero_nxt   = zero_r;
    ind_nxt    = ind_r;
    lat_nxt    = lat_r;
    in_isr_nxt = in_isr_r;
    for (int i = 0; i < 3; i++) begin
      dir_nxt[i] = dir_r[i];
    end
    ram_we  = 1'b0;
    ram_wa  = fa;
    ram_wd  = 8'h00;
    push    = 1'b0;
    pop     = 1'b0;
    // A call resumes after itself, an interrupt at the word it displaced
    push_addr = pc_r + 13'h0001;
    result  = 8'h00;
    to_file = 1'b0;
    case (st_r)
      sxd_pkg::SXD_SLEEP: begin
        if (irq_s2_r && irq_en_i) begin
          st_nxt = sxd_pkg::SXD_RUN;
        end
      end
      sxd_pkg::SXD_FLUSH: begin
        // Word fetched during a branch is discarded
        if (instr_valid_i) begin
          st_nxt = sxd_pkg::SXD_RUN;
        end
      end
      sxd_pkg::SXD_RUN: begin
        if (irq_take) begin
          push       = 1'b1;
          push_addr  = pc_r;
          in_isr_nxt = 1'b1;
          pc_nxt     = sxd_pkg::IRQ_VECTOR;
          st_nxt     = sxd_pkg::SXD_FLUSH;
        end else if (instr_valid_i) begin
          // Full fourteen-bit word decoded
          pc_nxt = pc_r + 13'h0001;
          if (is_op6(instr_i, sxd_pkg::OPC_SWAP)) begin
            result  = {fval[3:0], fval[7:4]};
            to_file = instr_i[sxd_pkg::DEST_BIT];
            if (!to_file) begin
              w_nxt = result;
            end
          end else if (is_op6(instr_i, sxd_pkg::OPC_XOR_FILE)) begin
            result   = w_r ^ fval;
            zero_nxt = (result == 8'h00);
            to_file  = instr_i[sxd_pkg::DEST_BIT];
            if (!to_file) begin
              w_nxt = result;
            end
          end else if (is_op6(instr_i, sxd_pkg::OPC_XOR_LIT)) begin
            w_nxt    = w_r ^ instr_i[7:0];
            zero_nxt = ((w_r ^ instr_i[7:0]) == 8'h00);
          end else if (instr_i == sxd_pkg::OPC_SLEEP) begin
            // Shares the direction-load prefix, so it is decoded first
            st_nxt = sxd_pkg::SXD_SLEEP;
          end else if (instr_i[13:3] == sxd_pkg::OPC_DIR_LOAD) begin
            // Other selectors below five are ignored
            if (instr_i[2:0] >= sxd_pkg::DIR_SEL_LO) begin
              dir_nxt[2'(instr_i[2:0] - sxd_pkg::DIR_SEL_LO)] = w_r;
            end
          end else if (instr_i == sxd_pkg::OPC_RETURN ||
                       instr_i == sxd_pkg::OPC_RETFIE) begin
            pop    = 1'b1;
            pc_nxt = stack_top;
            st_nxt = sxd_pkg::SXD_FLUSH;
            if (instr_i == sxd_pkg::OPC_RETFIE) begin
              in_isr_nxt = 1'b0;
            end
          end else if (instr_i[13:11] == sxd_pkg::OPC_CALL ||
                       instr_i[13:11] == sxd_pkg::OPC_GOTO) begin
            push   = (instr_i[13:11] == sxd_pkg::OPC_CALL);
            pc_nxt = {lat_r[4:3], instr_i[10:0]};
            st_nxt = sxd_pkg::SXD_FLUSH;
          end
          if (to_file) begin
            if (fa == sxd_pkg::ADDR_POINTER) begin
              ind_nxt = result;
            end else if (fa == sxd_pkg::ADDR_LATCH) begin
              lat_nxt = result[4:0];
            end else begin
              ram_we = 1'b1;
              ram_wd = result;
            end
          end
        end
      end
      default: begin
        st_nxt = sxd_pkg::SXD_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      st_r     <= sxd_pkg::SXD_RUN;
      pc_r     <= sxd_pkg::RESET_VECTOR;
      w_r      <= 8'h00;
      zero_r   <= 1'b0;
      ind_r    <= 8'h00;
      lat_r    <= 5'h00;
      in_isr_r <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        dir_r[i] <= sxd_pkg::DIR_RESET;
      end
    end else begin
      st_r     <= st_nxt;
      pc_r     <= pc_nxt;
      w_r      <= w_nxt;
      zero_r   <= zero_nxt;
      ind_r    <= ind_nxt;
      lat_r    <= lat_nxt;
      in_isr_r <= in_isr_nxt;
      for (int i = 0; i < 3; i++) begin
        dir_r[i] <= dir_nxt[i];
      end
    end
  end

  // Cleared at reset so a read before any write is defined
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < sxd_pkg::FILE_DEPTH; i++) begin
        ram_r[i] <= 8'h00;
      end
    end else if (ram_we) begin
      ram_r[ram_wa] <= ram_wd;
    end
  end

  assign prog_addr_o = pc_r;
  assign w_o         = w_r;
  assign zero_o      = zero_r;
  assign ind_ptr_o   = ind_r;
  assign pc_latch_o  = lat_r;
  assign sleeping_o  = st_r[2];
  assign dir_port5_o = dir_r[0];
  assign dir_port6_o = dir_r[1];
  assign dir_port7_o = dir_r[2];
endmodule // sxd_core

/* sxd_chk_assertions.sv */
// Concurrent checks on the execute core ports
`timescale 1ns/100ps
module sxd_chk (
  // Clock and reset
  input wire logic        mclk_i,
  input wire logic        rst_b_i,
  // Core ports
  input wire logic [13:0] instr_i,
  input wire logic        instr_valid_i,
  input wire logic [12:0] prog_addr_o,
  input wire logic        irq_i,
  input wire logic        irq_en_i,
  input wire logic [7:0]  w_o,
  input wire logic        zero_o,
  input wire logic [7:0]  ind_ptr_o,
  input wire logic        sleeping_o,
  input wire logic [7:0]  dir_port5_o,
  input wire logic [7:0]  dir_port6_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  // Conservative: skip words that a flush, sleep or interrupt may swallow
  logic        pv_r;
  logic [13:0] pi_r;
  logic [2:0]  ih_r;
  logic        ex;
  always_ff @(posedge mclk_i) begin
    pv_r <= instr_valid_i & rst_b_i;
    pi_r <= instr_i;
    ih_r <= {ih_r[1:0], irq_i};
  end
  assign ex = rst_b_i & instr_valid_i & ~sleeping_o & pv_r & ~|ih_r & ~irq_i
    & (pi_r[13:12] != 2'h2) & (pi_r[13:1] != 13'h0004);
  property p_rst;
    disable iff (1'b0) !rst_b_i |=> prog_addr_o == 13'h0000 && w_o == 8'h00 && dir_port5_o == 8'hFF;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_xlit;
    ex && instr_i[13:8] == 6'h3A |=> w_o == ($past(w_o) ^ $past(instr_i[7:0]))
      && zero_o == (w_o == 8'h00) && prog_addr_o == $past(prog_addr_o) + 13'h0001;
  endproperty
  a_xlit: assert property (p_xlit) else $error("xor literal");
  property p_swp;
    ex && instr_i == 14'h0E04 |=> w_o == {$past(ind_ptr_o[3:0]), $past(ind_ptr_o[7:4])} && $stable(zero_o);
  endproperty
  a_swp: assert property (p_swp) else $error("swap to W");
  property p_swpf;
    ex && instr_i == 14'h0E84 |=> ind_ptr_o == {$past(ind_ptr_o[3:0]), $past(ind_ptr_o[7:4])} && $stable(w_o);
  endproperty
  a_swpf: assert property (p_swpf) else $error("swap to file");
  property p_xf;
    ex && instr_i == 14'h0604 |=> w_o == ($past(w_o) ^ $past(ind_ptr_o))
      && zero_o == (w_o == 8'h00) && $stable(ind_ptr_o);
  endproperty
  a_xf: assert property (p_xf) else $error("xor file to W");
  property p_xfd;
    ex && instr_i == 14'h0684 |=> ind_ptr_o == ($past(w_o) ^ $past(ind_ptr_o)) && $stable(w_o);
  endproperty
  a_xfd: assert property (p_xfd) else $error("xor file to file");
  property p_dir;
    ex && instr_i == 14'h0066 |=> dir_port6_o == $past(w_o) && $stable(dir_port5_o) && $stable(zero_o);
  endproperty
  a_dir: assert property (p_dir) else $error("direction load");
  property p_irq;
    $rose(irq_i) && irq_en_i && !sleeping_o |-> ##[1:5] prog_addr_o == 13'h0004;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt vector");
  property p_wake;
    sleeping_o && irq_i && irq_en_i |-> ##[1:5] !sleeping_o;
  endproperty
  a_wake: assert property (p_wake) else $error("wake");
endmodule // sxd_chk

bind sxd_core sxd_chk sxd_chk_i (.mclk_i, .rst_b_i, .instr_i, .instr_valid_i, .prog_addr_o,
  .irq_i, .irq_en_i, .w_o, .zero_o, .ind_ptr_o, .sleeping_o, .dir_port5_o, .dir_port6_o);

/* tb.sv */
// Self-checking bench for the execute core
`timescale 1ns/100ps
module tb;
  typedef struct packed {
    logic [13:0] i;
    logic [7:0]  w;
    logic        z;
    logic [1:0]  c;
  } sxd_row_s;
  logic        mclk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [13:0] instr_i = 14'h0000;
  logic        instr_valid_i = 1'b0;
  logic        irq_i = 1'b0;
  logic        irq_en_i = 1'b0;
  logic [12:0] prog_addr_o;
  logic [7:0]  w_o, ind_ptr_o, dir_port5_o, dir_port6_o, dir_port7_o;
  logic [4:0]  pc_latch_o;
  logic        zero_o, sleeping_o;
  int          error_cnt = 0;
  int          samples_checked = 0;
  // File bytes start at zero after reset
  sxd_row_s rows [14] = '{
    '{14'h3AB5, 8'hB5, 1'h0, 2'h3}, '{14'h3AAF, 8'h1A, 1'h0, 2'h3},
    '{14'h3A1A, 8'h00, 1'h1, 2'h3}, '{14'h3AA5, 8'hA5, 1'h0, 2'h3},
    '{14'h067F, 8'hA5, 1'h0, 2'h3}, '{14'h06FF, 8'hA5, 1'h0, 2'h3},
    '{14'h0E7F, 8'h5A, 1'h0, 2'h2}, '{14'h3A5A, 8'h00, 1'h1, 2'h3},
    '{14'h0EFF, 8'h00, 1'h1, 2'h3}, '{14'h0E7F, 8'hA5, 1'h1, 2'h3},
    '{14'h06FF, 8'hA5, 1'h0, 2'h3}, '{14'h067F, 8'h5A, 1'h0, 2'h3},
    '{14'h3A5A, 8'h00, 1'h1, 2'h3}, '{14'h3AA5, 8'hA5, 1'h0, 2'h3}
  };
  sxd_core sxd_core_i (.mclk_i, .rst_b_i, .instr_i, .instr_valid_i, .prog_addr_o, .irq_i,
    .irq_en_i, .w_o, .zero_o, .ind_ptr_o, .pc_latch_o, .sleeping_o, .dir_port5_o,
    .dir_port6_o, .dir_port7_o);
  always #5 mclk_i = ~mclk_i;
  task automatic chk(input logic [23:0] s, input logic [23:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task automatic step(input logic [13:0] op);
    instr_i = op;
    instr_valid_i = 1'b1;
    @(posedge mclk_i);
    #1;
  endtask
  // Bounded wait, a lost vector shows up as a mismatch
  task automatic wait_vec;
    repeat (8) begin
      if (prog_addr_o !== 13'h0004 || sleeping_o !== 1'b0) begin
        @(posedge mclk_i);
        #1;
      end
    end
  endtask
  task automatic finish_test;
    $display("Checks %0d, errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #5000;
    error_cnt++;
    finish_test();
  end
  initial begin
    repeat (3) @(posedge mclk_i);
    #1;
    rst_b_i = 1'b1;
    chk(prog_addr_o, 24'h000000);
    chk({w_o, dir_port5_o, dir_port7_o}, 24'h00FFFF);
    for (int k = 0; k < 14; k++) begin
      step(rows[k].i);
      chk(prog_addr_o, 24'(k + 1));
      if (rows[k].c[1]) chk(w_o, rows[k].w);
      if (rows[k].c[0]) chk(zero_o, rows[k].z);
    end
    step(14'h0684);
    chk(ind_ptr_o, 8'hA5);
    step(14'h0E04);
    chk(w_o, 8'h5A);
    step(14'h0E84);
    chk(ind_ptr_o, 8'h5A);
    step(14'h0604);
    chk({w_o, zero_o}, 9'h001);
    step(14'h3A1F);
    step(14'h068A);
    chk(pc_latch_o, 5'h1F);
    step(14'h3A1F);
    // Selector four is below five, so the core ignores it; no direction register changes
    step(14'h0064);
    chk({dir_port5_o, dir_port6_o, dir_port7_o}, 24'hFFFFFF);
    step(14'h0065);
    step(14'h0066);
    step(14'h0067);
    chk({dir_port5_o, dir_port6_o, dir_port7_o}, 24'h000000);
    chk(zero_o, 1'b1);
    irq_en_i = 1'b1;
    instr_i = 14'h3A00;
    irq_i = 1'b1;
    wait_vec();
    chk(prog_addr_o, 13'h0004);
    irq_i = 1'b0;
    step(14'h3A00);
    step(14'h0009);
    step(14'h3A00);
    step(14'h0063);
    chk(sleeping_o, 1'b1);
    irq_i = 1'b1;
    wait_vec();
    chk({sleeping_o, prog_addr_o}, 14'h0004);
    irq_i = 1'b0;
    rst_b_i = 1'b0;
    @(posedge mclk_i);
    #1;
    rst_b_i = 1'b1;
    chk(prog_addr_o, 13'h0000);
    chk({w_o, ind_ptr_o, dir_port6_o}, 24'h0000FF);
    // Latch bits 4:3 page a call, then nest eight calls deep
    step(14'h3A18);
    step(14'h068A);
    step(14'h2123);
    chk(prog_addr_o, 24'h001923);
    step(14'h0000);
    step(14'h0008);
    chk(prog_addr_o, 24'h000003);
    step(14'h0000);
    for (int n = 0; n < 8; n++) begin
      step(14'h2100 + 14'(n));
      step(14'h0000);
    end
    for (int n = 0; n < 8; n++) begin
      step(14'h0008);
      step(14'h0000);
      chk(prog_addr_o, (n < 7) ? 24'h001907 - 24'(n) : 24'h000004);
    end
    finish_test();
  end
endmodule // tb
